/* File: design/upae_pkg.sv */
// Purpose: Shared constants and types for port attach and packet delimiter logic
// Assumes: 20 MHz system clock, one line sample per bit strobe
// Notes: Line states are encoded as the sampled (dp, dm) pair
`default_nettype none
package upae_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned MS_PER_S = 1000;
    // Reset drive time in milliseconds
    localparam int unsigned PORT_RESET_DURATION_MS = 10;
    localparam int unsigned PORT_RESET_CYCLES = (PORT_RESET_DURATION_MS * CLK_HZ) / MS_PER_S;
    localparam int unsigned RESET_CNT_W = 18;

    // Detach and attach filter defaults, in cycles (filters are parameters)
    localparam int unsigned DETACH_FILTER_DEF = 50;
    localparam int unsigned ATTACH_FILTER_DEF = 50;
    localparam int unsigned FILTER_W = 16;

    // Line states as {dp, dm}
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_LOW = 2'h1;  // dm high: low-speed idle / J at LS
    localparam logic [1:0] LS_FULL = 2'h2; // dp high: full-speed idle / J at FS

    // High-speed delimiter figures
    localparam logic [7:0] HS_EOP_PATTERN = 8'h7F; // NRZ 01111111, sent msb first
    localparam logic [5:0] HS_EOP_LEN = 6'h08;
    localparam logic [5:0] HS_SOF_EOP_LEN = 6'h28;
    localparam logic [5:0] HS_QUIET_RUN = 6'h20;
    localparam logic [5:0] HS_SAMPLE_POS = 6'h24; // one sample inside next 8 bits
    localparam logic [5:0] RUN_MAX = 6'h3F;

    // Low/full-speed delimiter figures
    localparam logic [1:0] LF_SE0_BITS = 2'h2;

    typedef enum logic [1:0] {
        UPAE_SPD_LOW = 2'h0,
        UPAE_SPD_FULL = 2'h1,
        UPAE_SPD_NONE = 2'h3
    } upae_speed_e;

    typedef enum logic [2:0] {
        UPAE_TX_IDLE = 3'h0,
        UPAE_TX_DATA = 3'h1,
        UPAE_TX_SE0 = 3'h3,
        UPAE_TX_J = 3'h2,
        UPAE_TX_HS_EOP = 3'h6
    } upae_tx_e;
endpackage
`default_nettype wire

/* File: design/upae_link_if.sv */
// Purpose: Data-line carrier between downstream port and attached function
// Assumes: Enables are active low; resolution done by the bench
// Notes: HS signals model current-mode drive as an on/level pair
`default_nettype none
interface upae_link_if;
    logic port_dp_o;
    logic port_dm_o;
    logic port_oe_n;
    logic fn_dp_o;
    logic fn_dm_o;
    logic fn_oe_n;
    logic fn_pull_dp;
    logic fn_pull_dm;
    logic line_dp;
    logic line_dm;
    logic port_hs_on;
    logic port_hs_lvl;
    logic env_detect;
    modport port (
        output port_dp_o, port_dm_o, port_oe_n, port_hs_on, port_hs_lvl,
        input line_dp, line_dm, env_detect
    );
    modport func (
        output fn_dp_o, fn_dm_o, fn_oe_n, fn_pull_dp, fn_pull_dm,
        input line_dp, line_dm, port_hs_on, port_hs_lvl
    );
endinterface
`default_nettype wire

/* File: design/upae_lf_tx.sv */
// Purpose: Low/full-speed packet framer: K start, data, SE0 x2, J, release
// Assumes: i_bit_stb marks each bit time; data given as line levels
// Notes: Used by both ends; no stuffing or NRZI here
`default_nettype none
module upae_lf_tx (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_bit_stb,
    input wire logic i_j_is_dp,
    input wire logic i_start,
    input wire logic i_valid,
    input wire logic i_bit,
    input wire logic i_last,
    output logic o_ready,
    output logic o_dp,
    output logic o_dm,
    output logic o_oe_n,
    output logic o_busy
);
    typedef struct packed {
        upae_pkg::upae_tx_e st;
        logic [1:0] cnt;
        logic dp;
        logic dm;
        logic oe_n;
    } upae_lftx_s;
    upae_lftx_s q, d;
    logic lvl_j, lvl_k;

    always_comb begin
        d = q;
        lvl_j = i_j_is_dp;
        lvl_k = ~i_j_is_dp;
        case (q.st)
            upae_pkg::UPAE_TX_IDLE: begin
                if (i_start && i_bit_stb) begin
                    // First K opens sync
                    d.st = upae_pkg::UPAE_TX_DATA;
                    d.dp = lvl_k;
                    d.dm = ~lvl_k;
                    d.oe_n = 1'b0;
                end
            end
            upae_pkg::UPAE_TX_DATA: begin
                if (i_bit_stb && i_valid) begin
                    d.dp = i_bit ? lvl_j : lvl_k;
                    d.dm = i_bit ? ~lvl_j : ~lvl_k;
                    if (i_last) begin
                        d.st = upae_pkg::UPAE_TX_SE0;
                        d.cnt = '0;
                    end
                end
            end
            upae_pkg::UPAE_TX_SE0: begin
                if (i_bit_stb) begin
                    d.dp = 1'b0;
                    d.dm = 1'b0;
                    d.cnt = q.cnt + 2'h1;
                    if (q.cnt == upae_pkg::LF_SE0_BITS - 2'h1) begin
                        d.st = upae_pkg::UPAE_TX_J;
                    end
                end
            end
            upae_pkg::UPAE_TX_J: begin
                if (i_bit_stb) begin
                    if (q.dp == lvl_j && q.dm == ~lvl_j) begin
                        d.oe_n = 1'b1;
                        d.st = upae_pkg::UPAE_TX_IDLE;
                    end else begin
                        d.dp = lvl_j;
                        d.dm = ~lvl_j;
                    end
                end
            end
            default: d.st = upae_pkg::UPAE_TX_IDLE;
        endcase
        if (i_rst) begin
            d = '{upae_pkg::UPAE_TX_IDLE, 2'h0, 1'b0, 1'b0, 1'b1};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        q <= d;
    end

    assign o_ready = (q.st == upae_pkg::UPAE_TX_DATA) && i_bit_stb;
    assign o_dp = q.dp;
    assign o_dm = q.dm;
    assign o_oe_n = q.oe_n;
    assign o_busy = (q.st != upae_pkg::UPAE_TX_IDLE);
endmodule
`default_nettype wire

/* File: design/upae_port.sv */
// Purpose: Downstream port: attach/detach filters, speed latch, reset drive, delimiters
// Assumes: Line inputs synchronous to i_clk_sys; bit strobe given by the user
// Notes: Filter times are parameters
// Function
// - Undriven SE0 beyond filter time flags detach
// - Line high beyond filter time flags attach
// - Latch speed from line just before reset
// - Bus-powered function attaches within 100 ms
// - Software debounces 100 ms, restarting on detach
// - Ten ms recovery after reset; ignore replies
// - High-speed function first attaches as full
// - Port still detects low and full speed
// - HS SOF EOP 40 quiet symbols, else 8
// - After 32 quiet bits sample envelope once
// - Envelope over threshold reports HS detach
// - LS/FS packet starts with idle-to-K
// - LS/FS EOP: two SE0 bits then J
// - Release drivers after the final J
// - SE0-to-J marks receive end of packet
// - HS EOP opposite symbol then 01111111
// - Stop current after HS EOP, back idle
// - Requested reset drives SE0 at least 10 ms
`default_nettype none
module upae_port #(
    parameter int unsigned DETACH_FILTER_TIME = upae_pkg::DETACH_FILTER_DEF,
    parameter int unsigned ATTACH_FILTER_TIME = upae_pkg::ATTACH_FILTER_DEF,
    parameter int unsigned RESET_CYCLES = upae_pkg::PORT_RESET_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    upae_link_if.port link,
    input wire logic i_bit_stb,
    input wire logic i_reset_req,
    input wire logic i_hs_mode,
    input wire logic i_tx_start,
    input wire logic i_tx_valid,
    input wire logic i_tx_bit,
    input wire logic i_tx_last,
    input wire logic i_tx_sof,
    output logic o_tx_ready,
    output logic o_attached,
    output logic o_detach_evt,
    output logic o_attach_evt,
    output logic o_hs_detach,
    output logic o_speed_full,
    output logic o_speed_valid,
    output logic o_reset_busy,
    output logic o_rx_eop
);
    typedef struct packed {
        logic [upae_pkg::FILTER_W-1:0] filt;
        logic attached;
        logic att_evt;
        logic det_evt;
        logic hs_det;
        upae_pkg::upae_speed_e speed;
        logic [upae_pkg::RESET_CNT_W-1:0] rst_cnt;
        logic rst_busy;
        logic [1:0] ls_prev;
        logic rx_eop;
        upae_pkg::upae_tx_e hs_st;
        logic [5:0] hs_cnt;
        logic [5:0] run;
        logic sampled;
        logic hs_on;
        logic hs_lvl;
        logic [7:0] hs_pat;
    } upae_port_s;
    upae_port_s q, d;

    logic [1:0] ls;
    logic lf_dp, lf_dm, lf_oe_n, lf_busy, lf_ready;
    logic hs_ready;
    logic driving;
    logic [5:0] eop_len;

    assign ls = {link.line_dp, link.line_dm};
    assign driving = lf_busy || q.rst_busy || q.hs_on;

    upae_lf_tx u_lf_tx (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_bit_stb(i_bit_stb),
        .i_j_is_dp(q.speed == upae_pkg::UPAE_SPD_FULL),
        .i_start(i_tx_start && !i_hs_mode && q.attached && !q.rst_busy),
        .i_valid(i_tx_valid),
        .i_bit(i_tx_bit),
        .i_last(i_tx_last),
        .o_ready(lf_ready),
        .o_dp(lf_dp),
        .o_dm(lf_dm),
        .o_oe_n(lf_oe_n),
        .o_busy(lf_busy)
    );

    always_comb begin
        d = q;
        d.att_evt = 1'b0;
        d.det_evt = 1'b0;
        d.rx_eop = 1'b0;
        // New packet clears a stale HS detach; a same-cycle detach below still wins
        if (i_tx_start) begin
            d.hs_det = 1'b0;
        end
        eop_len = i_tx_sof ? upae_pkg::HS_SOF_EOP_LEN : upae_pkg::HS_EOP_LEN;
        d.ls_prev = ls;
        // Attach filter covers LS and FS pull-ups alike, HS starts as FS
        if (!q.attached) begin
            if (ls != upae_pkg::LS_SE0) begin
                if (q.filt >= upae_pkg::FILTER_W'(ATTACH_FILTER_TIME)) begin
                    d.attached = 1'b1;
                    d.att_evt = 1'b1;
                    d.filt = '0;
                end else begin
                    d.filt = q.filt + 1'b1;
                end
            end else begin
                d.filt = '0;
            end
        end else if (!driving && !i_hs_mode && ls == upae_pkg::LS_SE0) begin
            if (q.filt >= upae_pkg::FILTER_W'(DETACH_FILTER_TIME)) begin
                d.attached = 1'b0;
                d.det_evt = 1'b1;
                d.speed = upae_pkg::UPAE_SPD_NONE;
                d.filt = '0;
            end else begin
                d.filt = q.filt + 1'b1;
            end
        end else begin
            d.filt = '0;
        end
        if (q.attached && ls == upae_pkg::LS_SE0 && q.ls_prev == upae_pkg::LS_SE0) begin
            d.rx_eop = 1'b0;
        end
        // End of packet seen as SE0 followed by J
        if (!driving && q.ls_prev == upae_pkg::LS_SE0 && ls != upae_pkg::LS_SE0) begin
            d.rx_eop = q.attached;
        end
        // Reset drive; speed latched from the line seen just before SE0
        if (i_reset_req && !q.rst_busy && q.attached && !lf_busy) begin
            d.rst_busy = 1'b1;
            d.rst_cnt = '0;
            d.speed = (ls == upae_pkg::LS_FULL) ? upae_pkg::UPAE_SPD_FULL
                                                : upae_pkg::UPAE_SPD_LOW;
        end else if (q.rst_busy) begin
            d.rst_cnt = q.rst_cnt + 1'b1;
            if (q.rst_cnt >= upae_pkg::RESET_CNT_W'(RESET_CYCLES - 1)) begin
                d.rst_busy = 1'b0;
            end
        end
        // High-speed transmit: data then EOP, with envelope watch
        hs_ready = 1'b0;
        case (q.hs_st)
            upae_pkg::UPAE_TX_IDLE: begin
                d.hs_on = 1'b0;
                if (i_tx_start && i_hs_mode && q.attached && !q.rst_busy && i_bit_stb) begin
                    d.hs_st = upae_pkg::UPAE_TX_DATA;
                    d.run = '0;
                    d.sampled = 1'b0;
                end
            end
            upae_pkg::UPAE_TX_DATA: begin
                if (i_bit_stb && i_tx_valid) begin
                    hs_ready = 1'b1;
                    d.hs_on = 1'b1;
                    d.hs_lvl = i_tx_bit;
                    if (i_tx_last) begin
                        d.hs_st = upae_pkg::UPAE_TX_HS_EOP;
                        d.hs_cnt = '0;
                        d.hs_pat = upae_pkg::HS_EOP_PATTERN;
                    end
                end
            end
            upae_pkg::UPAE_TX_HS_EOP: begin
                if (i_bit_stb) begin
                    if (q.hs_cnt == eop_len) begin
                        d.hs_on = 1'b0;
                        d.hs_st = upae_pkg::UPAE_TX_IDLE;
                    end else begin
                        // First symbol inverts, then holds; NRZ 0 toggles, 1 holds
                        d.hs_lvl = (q.hs_cnt == '0 || !q.hs_pat[7]) ? ~q.hs_lvl
                                                                     : q.hs_lvl;
                        d.hs_pat = {q.hs_pat[6:0], 1'b1};
                        d.hs_cnt = q.hs_cnt + 1'b1;
                    end
                end
            end
            default: d.hs_st = upae_pkg::UPAE_TX_IDLE;
        endcase
        if (i_bit_stb && q.hs_on) begin
            if (d.hs_lvl != q.hs_lvl) begin
                d.run = '0;
                d.sampled = 1'b0;
            end else if (q.run != upae_pkg::RUN_MAX) begin
                d.run = q.run + 1'b1;
            end
            // Single mid-window sample keeps one glitch from counting twice
            if (q.run == upae_pkg::HS_SAMPLE_POS && !q.sampled) begin
                d.sampled = 1'b1;
                if (link.env_detect) begin
                    d.hs_det = 1'b1;
                    d.attached = 1'b0;
                    d.det_evt = 1'b1;
                end
            end
        end
        if (i_rst) begin
            d = '0;
            d.speed = upae_pkg::UPAE_SPD_NONE;
            d.hs_st = upae_pkg::UPAE_TX_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        q <= d;
    end

    // Reset SE0 overrides framer output
    assign link.port_dp_o = q.rst_busy ? 1'b0 : lf_dp;
    assign link.port_dm_o = q.rst_busy ? 1'b0 : lf_dm;
    assign link.port_oe_n = q.rst_busy ? 1'b0 : lf_oe_n;
    assign link.port_hs_on = q.hs_on;
    assign link.port_hs_lvl = q.hs_lvl;
    assign o_tx_ready = lf_ready || hs_ready;
    assign o_attached = q.attached;
    assign o_attach_evt = q.att_evt;
    assign o_detach_evt = q.det_evt;
    assign o_hs_detach = q.hs_det;
    assign o_speed_full = (q.speed == upae_pkg::UPAE_SPD_FULL);
    assign o_speed_valid = (q.speed != upae_pkg::UPAE_SPD_NONE);
    assign o_reset_busy = q.rst_busy;
    assign o_rx_eop = q.rx_eop;
endmodule
`default_nettype wire

/* File: design/upae_func.sv */
// Purpose: Attached function end: pull-up attach, LS/FS framing, EOP receive
// Assumes: Line inputs synchronous; bus power already valid at reset release
// Notes: Attach comes on the first cycle after i_connect rises, well inside any deadline
`default_nettype none
module upae_func (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    upae_link_if.func link,
    input wire logic i_low_speed,
    input wire logic i_connect,
    input wire logic i_bit_stb,
    input wire logic i_tx_start,
    input wire logic i_tx_valid,
    input wire logic i_tx_bit,
    input wire logic i_tx_last,
    output logic o_tx_ready,
    output logic o_rx_eop,
    output logic o_bus_reset
);
    typedef struct packed {
        logic pull_dp;
        logic pull_dm;
        logic [1:0] ls_prev;
        logic rx_eop;
        logic bus_rst;
    } upae_func_s;
    upae_func_s q, d;
    logic [1:0] ls;
    logic lf_busy;

    assign ls = {link.line_dp, link.line_dm};

    upae_lf_tx u_lf_tx (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_bit_stb(i_bit_stb),
        .i_j_is_dp(!i_low_speed),
        .i_start(i_tx_start),
        .i_valid(i_tx_valid),
        .i_bit(i_tx_bit),
        .i_last(i_tx_last),
        .o_ready(o_tx_ready),
        .o_dp(link.fn_dp_o),
        .o_dm(link.fn_dm_o),
        .o_oe_n(link.fn_oe_n),
        .o_busy(lf_busy)
    );

    always_comb begin
        d = q;
        // HS-capable parts also attach with the FS pull-up
        d.pull_dp = i_connect && !i_low_speed;
        d.pull_dm = i_connect && i_low_speed;
        d.ls_prev = ls;
        d.rx_eop = !lf_busy && q.ls_prev == upae_pkg::LS_SE0
                   && ls != upae_pkg::LS_SE0;
        d.bus_rst = (ls == upae_pkg::LS_SE0) && (q.ls_prev == upae_pkg::LS_SE0);
        if (i_rst) begin
            d = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        q <= d;
    end

    assign link.fn_pull_dp = q.pull_dp;
    assign link.fn_pull_dm = q.pull_dm;
    assign o_rx_eop = q.rx_eop;
    assign o_bus_reset = q.bus_rst;
endmodule
`default_nettype wire

/* File: verif/upae_sva.sv */
// Purpose: Wire-level checks between the port and function ends
// Assumes: One bit time per clock, as the bench drives it
// Notes: Counters below measure run lengths that repetition cannot hold
`default_nettype none
module upae_sva #(
    parameter int unsigned RESET_CYCLES = 50
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic port_dp_o,
    input wire logic port_dm_o,
    input wire logic port_oe_n,
    input wire logic fn_dp_o,
    input wire logic fn_dm_o,
    input wire logic fn_oe_n,
    input wire logic line_dp,
    input wire logic line_dm,
    input wire logic port_hs_on,
    input wire logic port_hs_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [17:0] se0_cnt_q;
    logic [5:0] hs_run_q;
    logic hs_lvl_q;
    wire logic p_se0 = !port_oe_n && !port_dp_o && !port_dm_o;
    wire logic f_se0 = !fn_oe_n && !fn_dp_o && !fn_dm_o;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    // The HS run counter saturates so a stuck line cannot wrap back into range; the SE0 counter wraps
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            se0_cnt_q <= 18'h0;
            hs_run_q <= 6'h0;
            hs_lvl_q <= 1'b0;
        end else begin
            se0_cnt_q <= p_se0 ? se0_cnt_q + 18'h1 : 18'h0;
            hs_lvl_q <= port_hs_lvl;
            if (!port_hs_on) begin
                hs_run_q <= 6'h0;
            end else if (hs_run_q != 6'h0 && port_hs_lvl == hs_lvl_q) begin
                hs_run_q <= (hs_run_q == 6'h3F) ? hs_run_q : hs_run_q + 6'h1;
            end else begin
                hs_run_q <= 6'h1;
            end
        end
    end

    a_port_sop_k: assert property ($fell(port_oe_n) && (port_dp_o || port_dm_o) |->
        {port_dp_o, port_dm_o} == ~$past({line_dp, line_dm}))
        else $error("port packet did not open with K");
    a_port_eop_shape: assert property (!port_oe_n && !$past(port_oe_n) && p_se0 &&
        $past(port_dp_o || port_dm_o) |=> p_se0 ##1 (!port_oe_n && port_dp_o != port_dm_o)
        ##1 port_oe_n)
        else $error("port end of packet not two SE0, one J, release");
    a_fn_sop_k: assert property ($fell(fn_oe_n) && (fn_dp_o || fn_dm_o) |->
        {fn_dp_o, fn_dm_o} == ~$past({line_dp, line_dm}))
        else $error("function packet did not open with K");
    a_fn_eop_shape: assert property (!fn_oe_n && !$past(fn_oe_n) && f_se0 &&
        $past(fn_dp_o || fn_dm_o) |=> f_se0 ##1 (!fn_oe_n && fn_dp_o != fn_dm_o) ##1 fn_oe_n)
        else $error("function end of packet not two SE0, one J, release");
    a_reset_se0_hold: assert property ($fell(port_oe_n) && p_se0 |-> p_se0 [*8])
        else $error("reset SE0 broke off early");
    a_reset_span_min: assert property ($rose(port_oe_n) && $past(p_se0) |->
        32'(se0_cnt_q) >= RESET_CYCLES)
        else $error("reset SE0 shorter than reset span");
    a_hs_eop_len: assert property ($fell(port_hs_on) |->
        hs_run_q == upae_pkg::HS_EOP_LEN || hs_run_q == upae_pkg::HS_SOF_EOP_LEN)
        else $error("high-speed end of packet has wrong quiet length");
    a_hs_run_cap: assert property (port_hs_on |-> hs_run_q <= upae_pkg::HS_SOF_EOP_LEN)
        else $error("high-speed quiet run too long");
endmodule
`default_nettype wire

/* File: verif/upae_tb_top.sv */
// Purpose: Bench joining port and function ends across the link
// Assumes: Bit strobe every clock; short filter and reset counts
// Notes: Lines resolved here from drivers, pulls and HS current
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module upae_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned ATT = 20;
    localparam int unsigned DET = 20;
    localparam int unsigned RST = 50;
    // Scaled stand-ins for the software debounce and reset recovery waits
    localparam int unsigned DBN = 20;
    localparam int unsigned RCV = 10;
    logic i_clk_sys = 0, i_rst = 1, rq = 0, hs = 0, sof = 0, who = 0, ls = 0, con = 0;
    logic env = 0, st = 0, vl = 0, bt = 0, lt = 0;
    logic p_rdy, f_rdy, att, aev, dev, hsd, spf, spv, bsy, prx, frx, fbr;
    int fails = 0, n_checks = 0, c_aev, c_dev, c_prx, c_frx, c_fbr;
    wire logic rdy = who ? f_rdy : p_rdy;
    upae_link_if lk();
    always #25 i_clk_sys = ~i_clk_sys;
    // Undriven lines fall to the pulls, never hold a stale value
    assign lk.line_dp = !lk.port_oe_n ? lk.port_dp_o : !lk.fn_oe_n ? lk.fn_dp_o :
        lk.port_hs_on ? lk.port_hs_lvl : lk.fn_pull_dp;
    assign lk.line_dm = !lk.port_oe_n ? lk.port_dm_o : !lk.fn_oe_n ? lk.fn_dm_o :
        lk.port_hs_on ? !lk.port_hs_lvl : lk.fn_pull_dm;
    assign lk.env_detect = env;
    upae_port #(.DETACH_FILTER_TIME(DET), .ATTACH_FILTER_TIME(ATT), .RESET_CYCLES(RST))
    upae_port_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(lk.port), .i_bit_stb(1'b1),
        .i_reset_req(rq), .i_hs_mode(hs), .i_tx_start(st && !who), .i_tx_valid(vl && !who),
        .i_tx_bit(bt), .i_tx_last(lt), .i_tx_sof(sof), .o_tx_ready(p_rdy), .o_attached(att),
        .o_detach_evt(dev), .o_attach_evt(aev), .o_hs_detach(hsd), .o_speed_full(spf),
        .o_speed_valid(spv), .o_reset_busy(bsy), .o_rx_eop(prx));
    upae_func upae_func_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(lk.func),
        .i_low_speed(ls), .i_connect(con), .i_bit_stb(1'b1), .i_tx_start(st && who),
        .i_tx_valid(vl && who), .i_tx_bit(bt), .i_tx_last(lt), .o_tx_ready(f_rdy),
        .o_rx_eop(frx), .o_bus_reset(fbr));
    upae_sva #(.RESET_CYCLES(RST)) upae_sva_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .port_dp_o(lk.port_dp_o), .port_dm_o(lk.port_dm_o), .port_oe_n(lk.port_oe_n),
        .fn_dp_o(lk.fn_dp_o), .fn_dm_o(lk.fn_dm_o), .fn_oe_n(lk.fn_oe_n),
        .line_dp(lk.line_dp), .line_dm(lk.line_dm), .port_hs_on(lk.port_hs_on),
        .port_hs_lvl(lk.port_hs_lvl));
    // Pulses counted mid-cycle, clear of the edge updates
    always @(negedge i_clk_sys) begin
        c_aev += aev;
        c_dev += dev;
        c_prx += prx;
        c_frx += frx;
        c_fbr += fbr;
    end
    task automatic tick;
        @(posedge i_clk_sys);
        #2;
    endtask
    task automatic clr;
        c_aev = 0;
        c_dev = 0;
        c_prx = 0;
        c_frx = 0;
        c_fbr = 0;
    endtask
    task automatic send(input logic w, input logic [7:0] d, input int n);
        int k, g;
        who = w;
        st = 1;
        tick;
        st = 0;
        for (k = 0; k < n; k++) begin
            vl = 1;
            bt = d[k];
            lt = (k == n - 1);
            g = 0;
            #1;
            while (!rdy && g < 20) begin
                tick;
                g++;
            end
            tick;
        end
        vl = 0;
        lt = 0;
    endtask
    task automatic t_attach;
        int n;
        clr;
        con = 1;
        tick;
        con = 0;
        repeat (ATT + 10) tick;
        `CHK("glitch attach", 0, c_aev)
        con = 1;
        n = 0;
        while (att !== 1'b1 && n < ATT + 20) begin
            tick;
            n++;
        end
        tick;
        `CHK("attach time", 1'b1, n > ATT && n < ATT + 5)
        `CHK("attach pulses", 1, c_aev)
        `CHK("speed before reset", 1'b0, spv)
    endtask
    task automatic t_reset(input logic full);
        int n;
        repeat (DBN) tick;
        clr;
        rq = 1;
        tick;
        rq = 0;
        n = 0;
        while (bsy === 1'b1 && n < RST + 10) begin
            tick;
            n++;
        end
        `CHK("reset span", RST, n)
        `CHK("speed valid", 1'b1, spv)
        `CHK("speed full", full, spf)
        `CHK("function saw reset", 1'b1, c_fbr > 0)
    endtask
    task automatic t_lf;
        // End of reset SE0 looks like an end of packet to both ends; let it pass
        repeat (RCV) tick;
        clr;
        send(0, 8'h35, 6);
        repeat (10) tick;
        `CHK("function end seen", 1, c_frx)
        `CHK("port own end", 0, c_prx)
        clr;
        send(1, 8'hCA, 7);
        repeat (10) tick;
        `CHK("port end seen", 1, c_prx)
        `CHK("function own end", 0, c_frx)
    endtask
    task automatic t_hs;
        // Envelope high through a short packet: quiet run never reaches the sample
        hs = 1;
        env = 1;
        clr;
        send(0, 8'h55, 8);
        repeat (12) tick;
        `CHK("no early sample", 1'b0, hsd)
        sof = 1;
        send(0, 8'hAA, 8);
        repeat (50) tick;
        sof = 0;
        `CHK("hs detach", 1'b1, hsd)
        `CHK("hs detach event", 1, c_dev)
        `CHK("hs attached", 1'b0, att)
        env = 0;
        hs = 0;
    endtask
    task automatic t_detach;
        int n;
        repeat (ATT + 10) tick;
        clr;
        con = 0;
        n = 0;
        while (att === 1'b1 && n < DET + 20) begin
            tick;
            n++;
        end
        tick;
        `CHK("detach time", 1'b1, n > DET && n < DET + 5)
        `CHK("detach event", 1, c_dev)
        `CHK("speed after detach", 1'b0, spv)
        ls = 1;
        con = 1;
        repeat (ATT + 10) tick;
        `CHK("low-speed attach", 1'b1, att)
    endtask
    task automatic end_sim;
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) tick;
        i_rst = 0;
        t_attach;
        t_reset(1'b1);
        t_lf;
        t_hs;
        t_detach;
        t_reset(1'b0);
        end_sim;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        fails++;
        end_sim;
    end
endmodule
`default_nettype wire
